// *** idbc_cfg.svh ***
// Timing constants for the divide and bit-count unit
`ifndef IDBC_CFG_SVH
`define IDBC_CFG_SVH
`define IDBC_LAT_U8_REG     7'h11
`define IDBC_LAT_U8_MEM     7'h10
`define IDBC_LAT_S8_REG     7'h12
`define IDBC_LAT_S8_MEM     7'h14
`define IDBC_LAT_U_ZERO     7'h12
`define IDBC_LAT_S_ZERO     7'h16
`define IDBC_LAT_U_SMALL    7'h12
`define IDBC_LAT_U_BASE     7'h0f
`define IDBC_LAT_S_BASE     7'h16
`define IDBC_LAT_U_BIG16    7'h18
`define IDBC_LAT_U_BIG32    7'h28
`define IDBC_LAT_U_BIG64    7'h48
`define IDBC_LAT_S_BIG16    7'h1f
`define IDBC_LAT_S_BIG32    7'h2f
`define IDBC_LAT_S_BIG64    7'h4f
`define IDBC_MSB_SMALL_MAX  7'h02
`endif

// *** idbc_pkg.sv ***
// Types shared by the divide and bit-count unit
package idbc_pkg;
	typedef enum logic [1:0] {IDBC_SZ8 = 2'h0, IDBC_SZ16 = 2'h1, IDBC_SZ32 = 2'h2, IDBC_SZ64 = 2'h3} idbc_size_t;
	typedef enum logic [1:0] {IDBC_OP_UDIV = 2'h0, IDBC_OP_SDIV = 2'h1, IDBC_OP_POP = 2'h2, IDBC_OP_LZC = 2'h3} idbc_op_t;
	typedef enum logic [2:0] {IDBC_IDLE = 3'h1, IDBC_WAIT = 3'h2, IDBC_DONE = 3'h4} idbc_state_t;
endpackage

// *** idbc_bitcount.sv ***
// Combinational set-bit and leading-zero counters for 32 or 64 bit operands
`timescale 1ns/1ps
module idbc_bitcount
#(
	parameter int W = 64
)
(
	input  wire logic [W-1:0] operand,
	input  wire logic         wide_mode,
	output logic      [6:0]   set_count,
	output logic      [6:0]   lead_zeros
);
	logic [W-1:0] masked;
	logic         seen;

	// Upper half ignored in 32-bit mode
	assign masked = wide_mode ? operand : {{(W-32){1'b0}}, operand[31:0]};

	// Population count over the selected width
	always_comb
	begin
		set_count = 7'h00;
		for (int i = 0; i < W; i++)
			set_count = set_count + 7'(masked[i]);
	end

	// Scan from the top; all-zero input yields the width
	always_comb
	begin
		lead_zeros = 7'h00;
		seen       = 1'b0;
		for (int i = W - 1; i >= 0; i--)
		begin
			if (wide_mode || i < 32)
			begin
				if (masked[i])
					seen = 1'b1;
				else if (!seen)
					lead_zeros = lead_zeros + 7'h01;
			end
		end
	end
endmodule

// *** idbc_unit.sv ***
// Integer divide unit with variable latency plus bit-count functions
`timescale 1ns/1ps
`include "idbc_cfg.svh"
module idbc_unit
	import idbc_pkg::*;
#(
	parameter int W = 64
)
(
	input  wire logic         CLK,
	input  wire logic         RST_B,
	input  wire logic         START,
	input  wire idbc_op_t     OP,
	input  wire idbc_size_t   SIZE,
	input  wire logic         MEM_SRC,
	input  wire logic         WIDE_MODE,
	input  wire logic [W-1:0] DIVIDEND_UPPER_WORD,
	input  wire logic [W-1:0] DIVIDEND_LOWER,
	input  wire logic [W-1:0] DIVISOR,
	output logic              BUSY,
	output logic              DONE,
	output logic              DIV_ERROR,
	output logic      [W-1:0] QUOTIENT,
	output logic      [W-1:0] REMAINDER
);
	idbc_state_t            state_r, state_nxt;
	logic        [6:0]      cnt_r, cnt_nxt;
	logic                   busy_r, busy_nxt, done_r, done_nxt, err_r, err_nxt;
	logic        [W-1:0]    quo_r, quo_nxt, rem_r, rem_nxt;
	logic        [W-1:0]    q_calc, r_calc, q_pend_r, q_pend_nxt, r_pend_r, r_pend_nxt;
	logic                   e_calc, e_pend_r, e_pend_nxt;
	logic        [6:0]      lat, set_count, lead_zeros, msb_pos;
	logic        [2*W-1:0]  dvd, dvd_abs, q_wide, r_wide;
	logic        [W-1:0]    dsr, dsr_abs, upper_mag, lower_mag;
	logic                   dvd_neg, dsr_neg, is_signed;
	int                     n;

	idbc_bitcount #(.W(W)) u_bits
	(
		.operand    (DIVIDEND_LOWER),
		.wide_mode  (WIDE_MODE),
		.set_count  (set_count),
		.lead_zeros (lead_zeros)
	);

	// Operand width in bits for the divide size
	always_comb
	begin
		case (SIZE)
			IDBC_SZ8:  n = 8;
			IDBC_SZ16: n = 16;
			IDBC_SZ32: n = 32;
			default:   n = 64;
		endcase
	end

	// Assemble double-width dividend and divisor, sign extended when signed
	always_comb
	begin
		is_signed = (OP == IDBC_OP_SDIV);
		dvd = '0;
		dsr = '0;
		for (int i = 0; i < W; i++)
		begin
			if (i < n)
			begin
				dvd[i] = DIVIDEND_LOWER[i];
				dsr[i] = DIVISOR[i];
			end
		end
		for (int i = 0; i < W; i++)
		begin
			if (i < n)
				dvd[n + i] = DIVIDEND_UPPER_WORD[i];
		end
		dvd_neg = is_signed && dvd[2*n-1];
		dsr_neg = is_signed && dsr[n-1];
		for (int i = 0; i < 2*W; i++)
			if (i >= 2*n)
				dvd[i] = dvd_neg;
		for (int i = 0; i < W; i++)
			if (i >= n)
				dsr[i] = dsr_neg;
		dvd_abs = dvd_neg ? (~dvd + 1'b1) : dvd;
		dsr_abs = dsr_neg ? (~dsr + 1'b1) : dsr;
	end

	// Magnitude split and MSB position of the lower half of the dividend magnitude
	always_comb
	begin
		upper_mag = '0;
		lower_mag = '0;
		msb_pos   = 7'h00;
		for (int i = 0; i < W; i++)
		begin
			if (i < n)
			begin
				upper_mag[i] = dvd_abs[n + i];
				lower_mag[i] = dvd_abs[i];
				if (dvd_abs[i])
					msb_pos = 7'(i);
			end
		end
	end

	// Magnitude divide; sign fixed afterwards, overflow flagged
	always_comb
	begin
		e_calc = (dsr_abs == '0);
		q_wide = '0;
		r_wide = '0;
		if (!e_calc)
		begin
			q_wide = dvd_abs / {{W{1'b0}}, dsr_abs};
			r_wide = dvd_abs % {{W{1'b0}}, dsr_abs};
		end
		q_calc = (dvd_neg ^ dsr_neg) ? (~q_wide[W-1:0] + 1'b1) : q_wide[W-1:0];
		r_calc = dvd_neg ? (~r_wide[W-1:0] + 1'b1) : r_wide[W-1:0];
		for (int i = 0; i < 2*W; i++)
			if (i >= n && q_wide[i])
				e_calc = 1'b1;
		if (OP == IDBC_OP_POP)
		begin
			q_calc = {{(W-7){1'b0}}, set_count};
			r_calc = '0;
			e_calc = 1'b0;
		end
		else if (OP == IDBC_OP_LZC)
		begin
			q_calc = {{(W-7){1'b0}}, lead_zeros};
			r_calc = '0;
			e_calc = 1'b0;
		end
	end

	// Latency selection from size, signedness and dividend magnitude
	always_comb
	begin
		if (OP == IDBC_OP_POP || OP == IDBC_OP_LZC)
			lat = 7'h01;
		else if (SIZE == IDBC_SZ8)
		begin
			if (is_signed)
				lat = MEM_SRC ? `IDBC_LAT_S8_MEM : `IDBC_LAT_S8_REG;
			else
				lat = MEM_SRC ? `IDBC_LAT_U8_MEM : `IDBC_LAT_U8_REG;
		end
		else if (upper_mag != '0)
		begin
			case (SIZE)
				IDBC_SZ16: lat = is_signed ? `IDBC_LAT_S_BIG16 : `IDBC_LAT_U_BIG16;
				IDBC_SZ32: lat = is_signed ? `IDBC_LAT_S_BIG32 : `IDBC_LAT_U_BIG32;
				default:   lat = is_signed ? `IDBC_LAT_S_BIG64 : `IDBC_LAT_U_BIG64;
			endcase
		end
		else if (lower_mag == '0)
			lat = is_signed ? `IDBC_LAT_S_ZERO : `IDBC_LAT_U_ZERO;
		else if (is_signed)
			lat = `IDBC_LAT_S_BASE + msb_pos;
		else if (msb_pos <= `IDBC_MSB_SMALL_MAX)
			lat = `IDBC_LAT_U_SMALL;
		else
			lat = `IDBC_LAT_U_BASE + msb_pos;
	end

	// Sequencer: result captured at start, released after the latency
	always_comb
	begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		busy_nxt   = busy_r;
		done_nxt   = 1'b0;
		err_nxt    = err_r;
		quo_nxt    = quo_r;
		rem_nxt    = rem_r;
		q_pend_nxt = q_pend_r;
		r_pend_nxt = r_pend_r;
		e_pend_nxt = e_pend_r;
		case (state_r)
			IDBC_IDLE:
			begin
				// Starts while busy are ignored; the issuer waits for DONE
				if (START && lat <= 7'h01)
				begin
					// Single-cycle ops skip the wait so DONE follows the taking edge
					quo_nxt   = q_calc;
					rem_nxt   = r_calc;
					err_nxt   = e_calc;
					done_nxt  = 1'b1;
					state_nxt = IDBC_DONE;
				end
				else if (START)
				begin
					q_pend_nxt = q_calc;
					r_pend_nxt = r_calc;
					e_pend_nxt = e_calc;
					cnt_nxt    = lat - 7'h01;
					busy_nxt   = 1'b1;
					state_nxt  = IDBC_WAIT;
				end
			end
			IDBC_WAIT:
			begin
				if (cnt_r <= 7'h01)
				begin
					quo_nxt   = q_pend_r;
					rem_nxt   = r_pend_r;
					err_nxt   = e_pend_r;
					done_nxt  = 1'b1;
					busy_nxt  = 1'b0;
					state_nxt = IDBC_DONE;
				end
				else
					cnt_nxt = cnt_r - 7'h01;
			end
			IDBC_DONE:
				state_nxt = IDBC_IDLE;
			default:
			begin
				state_nxt = IDBC_IDLE;
				busy_nxt  = 1'b0;
			end
		endcase
	end

	// State and result registers
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_r  <= IDBC_IDLE;
			cnt_r    <= 7'h00;
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
			err_r    <= 1'b0;
			quo_r    <= '0;
			rem_r    <= '0;
			q_pend_r <= '0;
			r_pend_r <= '0;
			e_pend_r <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			busy_r   <= busy_nxt;
			done_r   <= done_nxt;
			err_r    <= err_nxt;
			quo_r    <= quo_nxt;
			rem_r    <= rem_nxt;
			q_pend_r <= q_pend_nxt;
			r_pend_r <= r_pend_nxt;
			e_pend_r <= e_pend_nxt;
		end
	end

	assign BUSY      = busy_r;
	assign DONE      = done_r;
	assign DIV_ERROR = err_r;
	assign QUOTIENT  = quo_r;
	assign REMAINDER = rem_r;
endmodule

// *** idbc_unit_monitor.sv ***
// Checker of latency and count relations
`timescale 1ns/1ps
module idbc_unit_monitor
	import idbc_pkg::*;
#(
	parameter int W = 64
)
(
	input wire logic       CLK,
	input wire logic       RST_B,
	input wire logic       START,
	input wire idbc_op_t   OP,
	input wire idbc_size_t SIZE,
	input wire logic       MEM_SRC,
	input wire logic       WIDE_MODE,
	input wire logic [W-1:0] DIVIDEND_UPPER_WORD,
	input wire logic [W-1:0] DIVIDEND_LOWER,
	input wire logic [W-1:0] DIVISOR,
	input wire logic       BUSY,
	input wire logic       DONE,
	input wire logic       DIV_ERROR,
	input wire logic [W-1:0] QUOTIENT,
	input wire logic [W-1:0] REMAINDER
);
	// Accepted request
	wire logic go = START & ~BUSY & ~DONE;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	a_done_one_cycle: assert property (DONE |=> !DONE)
		else $error("done too long");
	a_u8_reg_lat: assert property (go && OP == IDBC_OP_UDIV && SIZE == IDBC_SZ8 && !MEM_SRC |-> ##17 DONE)
		else $error("u8 latency");
	a_s8_mem_lat: assert property (go && OP == IDBC_OP_SDIV && SIZE == IDBC_SZ8 && MEM_SRC |-> ##20 DONE)
		else $error("s8 latency");
	a_u_zero_lat: assert property (go && OP == IDBC_OP_UDIV && SIZE == IDBC_SZ16
		&& DIVIDEND_UPPER_WORD == 0 && DIVIDEND_LOWER == 0 |-> ##18 DONE)
		else $error("zero latency");
	a_u16_big_lat: assert property (go && OP == IDBC_OP_UDIV && SIZE == IDBC_SZ16
		&& DIVIDEND_UPPER_WORD[15:0] != 0 |-> ##24 DONE)
		else $error("big latency");
	a_s16_big_lat: assert property (go && OP == IDBC_OP_SDIV && SIZE == IDBC_SZ16
		&& !DIVIDEND_UPPER_WORD[15] && DIVIDEND_UPPER_WORD[15:0] != 0 |-> ##31 DONE)
		else $error("signed big latency");
	a_busy_quiet: assert property (go && !OP[1] |=> BUSY && !DONE [*8])
		else $error("divide ends early");
	a_pop_value: assert property (go && OP == IDBC_OP_POP && WIDE_MODE
		|=> DONE && QUOTIENT == $countones($past(DIVIDEND_LOWER)))
		else $error("set count");
	a_lzc_zero: assert property (go && OP == IDBC_OP_LZC && !WIDE_MODE && DIVIDEND_LOWER[31:0] == 0
		|=> DONE && QUOTIENT == 64'h20)
		else $error("zero count");
endmodule
bind idbc_unit idbc_unit_monitor #(.W(W)) i_mon (.*);

// *** idbc_issue_model.sv ***
// Issue side model timing each request
`timescale 1ns/1ps
module idbc_issue_model
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic start,
	input  wire logic busy,
	input  wire logic done,
	output int        lat
);
	int n;
	// Refused starts leave the count alone
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			n <= 0;
		else if (done)
			n <= 0;
		else if (start && !busy && n == 0)
			n <= 1;
		else if (n != 0)
			n <= n + 1;
	end
	// Held count when done appears
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			lat <= 0;
		else if (done)
			lat <= n;
	end
endmodule

// *** int_divide_bitcount_unit_bench.sv ***
// Bench for the divide and bit-count unit
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("MISMATCH %0t bad", $time); end end
module int_divide_bitcount_unit_bench;
	import idbc_pkg::*;
	logic        clk = 0;
	logic        rst_b = 0;
	logic        start = 0;
	idbc_op_t    op = IDBC_OP_UDIV;
	idbc_size_t  sz = IDBC_SZ8;
	logic        mem = 0;
	logic        wide = 0;
	logic [63:0] up = 0;
	logic [63:0] lo = 0;
	logic [63:0] dv = 0;
	logic        busy;
	logic        done;
	logic        err;
	logic [63:0] quo;
	logic [63:0] rem;
	int          lat;
	int          cyc = 0;
	int          failures = 0;
	int          check_count = 0;
	idbc_unit i_dut (.CLK(clk), .RST_B(rst_b), .START(start), .OP(op), .SIZE(sz), .MEM_SRC(mem),
		.WIDE_MODE(wide), .DIVIDEND_UPPER_WORD(up), .DIVIDEND_LOWER(lo), .DIVISOR(dv),
		.BUSY(busy), .DONE(done), .DIV_ERROR(err), .QUOTIENT(quo), .REMAINDER(rem));
	idbc_issue_model i_iss (.clk(clk), .rst_b(rst_b), .start(start), .busy(busy), .done(done), .lat(lat));
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	task automatic final_report;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One request, bounded wait, latency judged
	task automatic run(input idbc_op_t o, input idbc_size_t s, input logic m,
		input logic w, input logic [63:0] u, l, d, input int e);
		int k;
		@(posedge clk);
		start <= 1;
		op <= o;
		sz <= s;
		mem <= m;
		wide <= w;
		up <= u;
		lo <= l;
		dv <= d;
		@(posedge clk);
		start <= 0;
		#1;
		for (k = 0; k < 100 && done !== 1'b1; k++)
			@(posedge clk) #1;
		`CHK(done, 1'b1)
		@(posedge clk) #1;
		`CHK(lat, e)
	endtask
	task automatic t_div8;
		run(IDBC_OP_UDIV, IDBC_SZ8, 0, 1, 0, 100, 7, 17);
		`CHK(quo[7:0], 8'h0e)
		`CHK(rem[7:0], 8'h02)
		run(IDBC_OP_UDIV, IDBC_SZ8, 1, 1, 0, 100, 7, 16);
		run(IDBC_OP_SDIV, IDBC_SZ8, 0, 1, 8'hff, 8'h9c, 7, 18);
		`CHK(quo[7:0], 8'hf2)
		`CHK(rem[7:0], 8'hfe)
		run(IDBC_OP_SDIV, IDBC_SZ8, 1, 1, 8'hff, 8'h9c, 7, 20);
	endtask
	task automatic t_small;
		run(IDBC_OP_UDIV, IDBC_SZ16, 0, 1, 0, 0, 3, 18);
		run(IDBC_OP_SDIV, IDBC_SZ32, 0, 1, 0, 0, 3, 22);
		run(IDBC_OP_UDIV, IDBC_SZ32, 0, 1, 0, 4, 3, 18);
		run(IDBC_OP_UDIV, IDBC_SZ64, 0, 1, 0, 8, 3, 18);
		run(IDBC_OP_UDIV, IDBC_SZ16, 0, 1, 0, 16'h8000, 3, 30);
		`CHK(quo[15:0], 16'h2aaa)
		`CHK(rem[15:0], 16'h0002)
		run(IDBC_OP_SDIV, IDBC_SZ32, 0, 1, 32'hffffffff, 32'hfffffff0, 4, 26);
		`CHK(quo[31:0], 32'hfffffffc)
		// Zero divisor still runs the full latency, then flags the error
		run(IDBC_OP_UDIV, IDBC_SZ16, 0, 1, 0, 100, 0, 21);
		`CHK(err, 1'b1)
	endtask
	// Upper word of one: 8 or 15 plus the divide width
	task automatic t_big;
		for (int i = 1; i < 4; i++)
		begin
			run(IDBC_OP_UDIV, idbc_size_t'(i), 0, 1, 1, 0, 4, 8 + (8 << i));
			run(IDBC_OP_SDIV, idbc_size_t'(i), 0, 1, 1, 0, 4, 15 + (8 << i));
			`CHK(err, 1'b0)
		end
	endtask
	task automatic t_bits;
		run(IDBC_OP_POP, IDBC_SZ8, 0, 1, 0, 64'hf0f0000000000001, 0, 1);
		`CHK(quo, 64'h9)
		`CHK(rem, 64'h0)
		run(IDBC_OP_POP, IDBC_SZ8, 0, 0, 0, 64'hffffffff00000003, 0, 1);
		`CHK(quo, 64'h2)
		run(IDBC_OP_LZC, IDBC_SZ8, 0, 0, 0, 64'hffffffff00010000, 0, 1);
		`CHK(quo, 64'hf)
		run(IDBC_OP_LZC, IDBC_SZ8, 0, 1, 0, 1, 0, 1);
		`CHK(quo, 64'h3f)
		run(IDBC_OP_LZC, IDBC_SZ8, 0, 1, 0, 0, 0, 1);
		`CHK(quo, 64'h40)
		run(IDBC_OP_LZC, IDBC_SZ8, 0, 0, 0, 0, 0, 1);
		`CHK(quo, 64'h20)
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			final_report;
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst_b <= 1;
		t_div8;
		t_small;
		t_big;
		t_bits;
		final_report;
	end
endmodule
